// ==== src/vcp_ctl.sv ====
// control register bank for VBI pedestal, sync alignment, genlock and captions
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

module vcp_ctl
	import vcp_pkg::*;
#(
	parameter logic [9:0] CC_LINE_OFS = 10'h00A
)
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// video timing inputs
	input  wire logic        hsync_input,
	input  wire logic        vsync_input,
	input  wire logic        pal_mode,
	input  wire logic        field_odd,
	input  wire logic [9:0]  line_count,
	input  wire logic        active_line,
	// genlock stream flags
	input  wire logic        pal_phase_flag,
	input  wire logic        color_frame_bit,
	// control outputs
	output logic             field1_start,
	output logic             pal_phase_flip,
	output logic             field_seq_load,
	output logic             pedestal_on,
	output logic [6:0]       comp_pedestal,
	output logic [5:0]       active_start_line,
	output logic             vbi_blank,
	output logic             half_line_blank,
	output logic [9:0]       eq_high_total,
	output logic [9:0]       vs_low_total,
	output logic             cc_send,
	output logic [7:0]       cc_tx_first,
	output logic [7:0]       cc_tx_second,
	output logic             pixel_data_ctl_out
);

	// widened by one bit so a too large offset cannot wrap past the check
	if ({1'b0, CC_LINE_OFS} + 11'h00F > 11'h3FF || CC_LINE_OFS == 10'h000)
	begin
		$error("caption line offset out of range");
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0]  ped_high_r, ped_low_r, glk_f1_r, f2_r, ped_lvl_r;
	logic [7:0]  cc_first_r, cc_second_r, cc_ctl_r, pdc_cnt_r;
	logic [7:0]  eq_high_r, vs_low_r;
	logic [14:0] odd_ped_enable_vector;
	logic [7:0]  idx;
	logic        acc, wr_en, addr_ok;
	logic [7:0]  rd_nxt;
	logic        cc_latch;

	assign idx = paddr[9:2];
	assign acc = psel && penable && pready;
	assign wr_en = acc && pwrite && !pslverr;
	assign odd_ped_enable_vector = {ped_high_r, ped_low_r[7:1]};

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	always_comb
	begin
		addr_ok = (paddr[1:0] == 2'b00);
		rd_nxt = 8'h00;
		if (idx == IDX_ODD_PED_HIGH)
			rd_nxt = ped_high_r;
		else if (idx == IDX_ODD_PED_LOW)
			rd_nxt = ped_low_r;
		else if (idx == IDX_GLK_F1)
			rd_nxt = glk_f1_r;
		else if (idx == IDX_F2_OFS)
			rd_nxt = f2_r;
		else if (idx == IDX_PED_LEVEL)
			rd_nxt = ped_lvl_r;
		else if (idx == IDX_CC_FIRST)
			rd_nxt = cc_first_r;
		else if (idx == IDX_CC_SECOND)
			rd_nxt = cc_second_r;
		else if (idx == IDX_CC_CTL)
			rd_nxt = cc_ctl_r;
		else if (idx == IDX_PDC_START)
			rd_nxt = pdc_cnt_r;
		else if (idx == IDX_EQ_HIGH)
			rd_nxt = eq_high_r;
		else if (idx == IDX_VS_LOW)
			rd_nxt = vs_low_r;
		else
			addr_ok = 1'b0;
	end

	// no wait state: pready and read data are registered in the setup cycle so read data leaves a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (psel && !penable)
				prdata <= {24'h00_0000, rd_nxt};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ped_high_r <= REG_RST;
			ped_low_r <= REG_RST;
			glk_f1_r <= REG_RST;
			f2_r <= REG_RST;
			ped_lvl_r <= REG_RST;
			cc_first_r <= REG_RST;
			cc_second_r <= REG_RST;
			pdc_cnt_r <= REG_RST;
			eq_high_r <= REG_RST;
			vs_low_r <= REG_RST;
		end
		else if (wr_en)
		begin
			// reserved bits masked off at write
			if (idx == IDX_ODD_PED_HIGH)
				ped_high_r <= pwdata[7:0];
			else if (idx == IDX_ODD_PED_LOW)
				ped_low_r <= pwdata[7:0];
			else if (idx == IDX_GLK_F1)
				glk_f1_r <= pwdata[7:0] & 8'h7F;
			else if (idx == IDX_F2_OFS)
				f2_r <= pwdata[7:0] & 8'h7F; // test bit dropped
			else if (idx == IDX_PED_LEVEL)
				ped_lvl_r <= pwdata[7:0] & 8'h7F;
			else if (idx == IDX_CC_FIRST)
				cc_first_r <= pwdata[7:0];
			else if (idx == IDX_CC_SECOND)
				cc_second_r <= pwdata[7:0];
			else if (idx == IDX_PDC_START)
				pdc_cnt_r <= pwdata[7:0];
			else if (idx == IDX_EQ_HIGH)
				eq_high_r <= pwdata[7:0];
			else if (idx == IDX_VS_LOW)
				vs_low_r <= pwdata[7:0];
		end
	end

	// request bit: a software set wins over the hardware clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cc_ctl_r <= REG_RST;
		else if (wr_en && idx == IDX_CC_CTL)
			cc_ctl_r <= pwdata[7:0];
		else if (cc_latch)
			cc_ctl_r[CC_RTS_BIT] <= 1'b0;
	end

	// ----------------------------------------
	// sync alignment
	// ----------------------------------------
	logic       hs_d_r, vs_d_r, hs_fall, vs_fall;
	logic [5:0] hs_age_r, vs_age_r;
	logic       relax;

	assign relax = ped_low_r[ALIGN_BIT];
	assign hs_fall = hs_d_r && !hsync_input;
	assign vs_fall = vs_d_r && !vsync_input;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hs_d_r <= 1'b1;
			vs_d_r <= 1'b1;
			hs_age_r <= 6'h3F;
			vs_age_r <= 6'h3F;
		end
		else
		begin
			hs_d_r <= hsync_input;
			vs_d_r <= vsync_input;
			if (hs_fall)
				hs_age_r <= 6'h01;
			else if (hs_age_r != 6'h3F)
				hs_age_r <= hs_age_r + 6'h01;
			if (vs_fall)
				vs_age_r <= 6'h01;
			else if (vs_age_r != 6'h3F)
				vs_age_r <= vs_age_r + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			field1_start <= 1'b0;
		else if (!relax)
			field1_start <= hs_fall && vs_fall;
		else
			field1_start <= (hs_fall && (vs_fall || vs_age_r <= ALIGN_WIN))
				|| (vs_fall && hs_age_r <= ALIGN_WIN);
	end

	// ----------------------------------------
	// genlock, pedestal, blanking
	// ----------------------------------------
	logic       f1_sel, ped_line_on;
	logic [5:0] start_line;

	// field 1 means NTSC even or PAL odd
	assign f1_sel = pal_mode ? field_odd : !field_odd;
	assign start_line = (f1_sel ? {1'b0, glk_f1_r[4:0]} : {1'b0, f2_r[4:0]})
		+ (pal_mode ? START_OFS_PAL : START_OFS_NT);

	always_comb
	begin
		ped_line_on = 1'b0;
		if (field_odd && line_count >= PED_FIRST_LN && line_count < PED_RANGE_LN)
			ped_line_on = odd_ped_enable_vector[4'(line_count - PED_FIRST_LN)];
		else if (field_odd && line_count >= PED_RANGE_LN && line_count <= PED_LAST_LN)
			ped_line_on = odd_ped_enable_vector[14];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pal_phase_flip <= 1'b0;
			field_seq_load <= 1'b0;
			pedestal_on <= 1'b0;
			comp_pedestal <= 7'h00;
			active_start_line <= 6'h00;
			vbi_blank <= 1'b0;
			half_line_blank <= 1'b0;
		end
		else
		begin
			pal_phase_flip <= glk_f1_r[PAL_PH_BIT] && pal_phase_flag;
			field_seq_load <= glk_f1_r[CFRAME_BIT] && color_frame_bit;
			pedestal_on <= ped_line_on;
			// two's complement step; 7'h16 is the 7.5 IRE setup
			comp_pedestal <= ped_line_on ? ped_lvl_r[6:0] : 7'h00;
			active_start_line <= start_line;
			vbi_blank <= line_count < {4'h0, start_line};
			half_line_blank <= !f2_r[HALF_BIT]
				&& line_count == (pal_mode ? HALF_LN_PAL : HALF_LN_NTSC);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			eq_high_total <= DUR_OFS_SHORT;
			vs_low_total <= DUR_OFS_SHORT;
		end
		else
		begin
			eq_high_total <= (f2_r[LONG_BIT] ? DUR_OFS_LONG : DUR_OFS_SHORT)
				+ {2'b00, eq_high_r};
			vs_low_total <= (f2_r[LONG_BIT] ? DUR_OFS_LONG : DUR_OFS_SHORT)
				+ {2'b00, vs_low_r};
		end
	end

	// ----------------------------------------
	// caption insertion
	// ----------------------------------------
	logic [9:0] cc_line;
	logic       cc_field_ok, cc_ln_d_r, cc_on_line, pend_r;
	logic [7:0] tx1_nxt, tx2_nxt;

	assign cc_line = CC_LINE_OFS + {6'h00, cc_ctl_r[3:0]};
	assign cc_field_ok = cc_ctl_r[CC_FLD_BIT] ? !field_odd : field_odd;
	assign cc_on_line = cc_field_ok && line_count == cc_line;
	// latch only once, on the first cycle of the preceding line
	assign cc_latch = cc_field_ok && line_count == cc_line - 10'h001 && !cc_ln_d_r
		&& cc_ctl_r[CC_EN_BIT];

	always_comb
	begin
		tx1_nxt = cc_first_r;
		tx2_nxt = cc_second_r;
		if (cc_ctl_r[CC_PAR_BIT])
		begin
			tx1_nxt[7] = ~^cc_first_r[6:0];
			tx2_nxt[7] = ~^cc_second_r[6:0];
		end
		if (!cc_ctl_r[CC_RTS_BIT])
		begin
			tx1_nxt = CC_NULL_BYTE;
			tx2_nxt = CC_NULL_BYTE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cc_ln_d_r <= 1'b0;
			pend_r <= 1'b0;
			cc_send <= 1'b0;
			cc_tx_first <= CC_NULL_BYTE;
			cc_tx_second <= CC_NULL_BYTE;
		end
		else
		begin
			cc_ln_d_r <= cc_field_ok && line_count == cc_line - 10'h001;
			if (cc_latch)
			begin
				cc_tx_first <= tx1_nxt;
				cc_tx_second <= tx2_nxt;
			end
			// one send pulse as the caption line starts
			cc_send <= pend_r && cc_on_line;
			if (cc_latch)
				pend_r <= 1'b1;
			else if (cc_on_line)
				pend_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// pixel data control
	// ----------------------------------------
	logic [8:0] pix_cnt_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pix_cnt_r <= 9'h1FF;
			pixel_data_ctl_out <= 1'b0;
		end
		else
		begin
			// saturate so a long line cannot retrigger the edge
			if (hs_fall)
				pix_cnt_r <= 9'h000;
			else if (pix_cnt_r != 9'h1FF)
				pix_cnt_r <= pix_cnt_r + 9'h001;
			if (hs_fall)
				pixel_data_ctl_out <= 1'b0;
			else if (active_line && pix_cnt_r == {1'b0, pdc_cnt_r})
				pixel_data_ctl_out <= 1'b1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_pdc_rise_time: assert property (
		$rose(pixel_data_ctl_out) |-> $past(active_line)
			&& $past(pix_cnt_r) == {1'b0, $past(pdc_cnt_r)})
		else $error("pixel control rose at wrong count");
	chk_strict_align: assert property (
		(!relax && hs_fall && !vs_fall) |=> !field1_start)
		else $error("field start without aligned syncs");
	chk_relax_window: assert property (
		(relax && hs_fall && vs_age_r > ALIGN_WIN && !vs_fall) |=> !field1_start)
		else $error("vsync outside window accepted");
	chk_rts_cleared: assert property (
		(cc_latch && !(wr_en && idx == IDX_CC_CTL)) |=> !cc_ctl_r[CC_RTS_BIT]
			&& cc_tx_first == $past(tx1_nxt))
		else $error("request not cleared at latch");
	chk_null_bytes: assert property (
		(cc_latch && !cc_ctl_r[CC_RTS_BIT]) |=> cc_tx_first == CC_NULL_BYTE
			&& cc_tx_second == CC_NULL_BYTE)
		else $error("null bytes not sent");
	chk_odd_parity: assert property (
		(cc_latch && cc_ctl_r[CC_RTS_BIT] && cc_ctl_r[CC_PAR_BIT])
			|=> ^cc_tx_first == 1'b1 && ^cc_tx_second == 1'b1)
		else $error("caption parity not odd");
	chk_dur_offset: assert property (
		$stable(f2_r) && $stable(eq_high_r) |=> eq_high_total
			== ($past(f2_r[LONG_BIT]) ? 10'h200 : 10'h100) + {2'b00, $past(eq_high_r)})
		else $error("duration offset wrong");
	chk_half_line: assert property (
		half_line_blank |-> $past(!f2_r[HALF_BIT]))
		else $error("half line blanked while enabled");
	chk_pal_flip: assert property (
		pal_phase_flip |-> $past(glk_f1_r[PAL_PH_BIT]) && $past(pal_phase_flag))
		else $error("pal flag not gated");
	chk_read_answer: assert property (
		(psel && !penable) |=> pready ##1 !pready)
		else $error("apb answer not one cycle");

	cov_cc_data: cover property (cc_latch && cc_ctl_r[CC_RTS_BIT] ##[1:1000] cc_send);
	cov_cc_null: cover property (cc_latch && !cc_ctl_r[CC_RTS_BIT]);
	cov_relax_start: cover property (relax && field1_start && !hs_fall);
	cov_pdc: cover property ($rose(pixel_data_ctl_out));

endmodule

// ==== src/vcp_pkg.sv ====
// register map and constants for the caption and pedestal control bank
package vcp_pkg;

	// ----------------------------------------
	// register indices (byte address = 4 x index)
	// ----------------------------------------
	localparam logic [7:0] IDX_ODD_PED_HIGH = 8'h16;
	localparam logic [7:0] IDX_ODD_PED_LOW  = 8'h17;
	localparam logic [7:0] IDX_GLK_F1       = 8'h18;
	localparam logic [7:0] IDX_F2_OFS       = 8'h19;
	localparam logic [7:0] IDX_PED_LEVEL    = 8'h1A;
	localparam logic [7:0] IDX_CC_FIRST     = 8'h1C;
	localparam logic [7:0] IDX_CC_SECOND    = 8'h1D;
	localparam logic [7:0] IDX_CC_CTL       = 8'h1E;
	localparam logic [7:0] IDX_PDC_START    = 8'h1F;
	localparam logic [7:0] IDX_EQ_HIGH      = 8'h29;
	localparam logic [7:0] IDX_VS_LOW       = 8'h2A;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ALIGN_BIT   = 0;
	localparam int PAL_PH_BIT  = 6;
	localparam int CFRAME_BIT  = 5;
	localparam int LONG_BIT    = 6;
	localparam int HALF_BIT    = 5;
	localparam int CC_EN_BIT   = 7;
	localparam int CC_RTS_BIT  = 6;
	localparam int CC_PAR_BIT  = 5;
	localparam int CC_FLD_BIT  = 4;

	// ----------------------------------------
	// reset values and fixed numbers
	// ----------------------------------------
	localparam logic [7:0] REG_RST       = 8'h00;
	localparam logic [7:0] CC_NULL_BYTE  = 8'h80;
	localparam logic [9:0] DUR_OFS_SHORT = 10'h100;
	localparam logic [9:0] DUR_OFS_LONG  = 10'h200;
	localparam logic [9:0] PED_FIRST_LN  = 10'h111;
	localparam logic [9:0] PED_RANGE_LN  = 10'h11F;
	localparam logic [9:0] PED_LAST_LN   = 10'h20D;
	localparam logic [9:0] HALF_LN_NTSC  = 10'h11B;
	localparam logic [9:0] HALF_LN_PAL   = 10'h017;
	localparam logic [5:0] START_OFS_NT  = 6'h04;
	localparam logic [5:0] START_OFS_PAL = 6'h01;
	localparam logic [5:0] ALIGN_WIN     = 6'h20;

endpackage

// ==== verif/tb_top.sv ====
// self-checking bench for the caption and pedestal control bank
`timescale 1ns/1ps

module tb_top;
	import vcp_pkg::*;

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        hsync_input, vsync_input, pal_mode, field_odd, active_line;
	logic [9:0]  line_count, eq_high_total, vs_low_total;
	logic        pal_phase_flag, color_frame_bit, field1_start, pal_phase_flip;
	logic        field_seq_load, pedestal_on, vbi_blank, half_line_blank, cc_send;
	logic [6:0]  comp_pedestal;
	logic [5:0]  active_start_line;
	logic [7:0]  cc_tx_first, cc_tx_second;
	logic        pixel_data_ctl_out, rerr, hs_d, pdc_d;
	int          err_total, compares, f1_cnt, hs_age, pdc_at, i, c0, m1;

	// address map, readable mask, pedestal lines
	logic [7:0] ix_t[11] = '{IDX_ODD_PED_HIGH, IDX_ODD_PED_LOW, IDX_GLK_F1, IDX_F2_OFS,
		IDX_PED_LEVEL, IDX_CC_FIRST, IDX_CC_SECOND, IDX_CC_CTL, IDX_PDC_START,
		IDX_EQ_HIGH, IDX_VS_LOW};
	logic [7:0] msk_t[11] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF};
	logic [9:0] pl_t[7] = '{10'd273, 10'd274, 10'd279, 10'd285, 10'd286, 10'd525, 10'd273};
	logic       po_t[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	logic       pe_t[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	int         rl_t[6] = '{0, 0, 1, 1, 1, 1};
	int         lg_t[6] = '{0, 3, 32, -32, 33, -33};
	int         fx_t[6] = '{1, 0, 1, 1, 0, 0};

	vcp_ctl #(.CC_LINE_OFS(10'h00A)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .hsync_input(hsync_input),
		.vsync_input(vsync_input), .pal_mode(pal_mode), .field_odd(field_odd),
		.line_count(line_count), .active_line(active_line),
		.pal_phase_flag(pal_phase_flag), .color_frame_bit(color_frame_bit),
		.field1_start(field1_start), .pal_phase_flip(pal_phase_flip),
		.field_seq_load(field_seq_load), .pedestal_on(pedestal_on),
		.comp_pedestal(comp_pedestal), .active_start_line(active_start_line),
		.vbi_blank(vbi_blank), .half_line_blank(half_line_blank),
		.eq_high_total(eq_high_total), .vs_low_total(vs_low_total), .cc_send(cc_send),
		.cc_tx_first(cc_tx_first), .cc_tx_second(cc_tx_second),
		.pixel_data_ctl_out(pixel_data_ctl_out));

	vcp_video_src src (.pclk(pclk), .hsync_input(hsync_input), .vsync_input(vsync_input),
		.pal_mode(pal_mode), .field_odd(field_odd), .line_count(line_count),
		.active_line(active_line), .pal_phase_flag(pal_phase_flag),
		.color_frame_bit(color_frame_bit));

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ----------------------------------------
	// event monitors
	// ----------------------------------------
	always @(posedge pclk)
	begin
		if (field1_start === 1'b1)
			f1_cnt++;
		hs_d <= hsync_input;
		hs_age <= (hs_d === 1'b1 && hsync_input === 1'b0) ? 0 : hs_age + 1;
		pdc_d <= pixel_data_ctl_out;
		if (pixel_data_ctl_out === 1'b1 && pdc_d === 1'b0)
			pdc_at <= hs_age;
	end

	// ----------------------------------------
	// apb master and helpers
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no assumed wait count: only the watchdog ends a hung access
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		apb(1'b1, ix, d);
		// outputs derived from a register trail its write by one cycle
		repeat (2) @(posedge pclk);
	endtask

	task automatic rd_chk(input logic [7:0] ix, input logic [7:0] e);
		apb(1'b0, ix, 8'h00);
		`CHK(rdat, {24'h000000, e});
	endtask

	task automatic ln(input logic pal, input logic odd, input logic [9:0] l, input logic a);
		src.set_line(pal, odd, l, a);
		repeat (3) @(posedge pclk);
	endtask

	task automatic cc_pulse(input logic odd);
		int n;
		n = 0;
		// enter the caption line here so the one-cycle pulse is not missed
		src.set_line(1'b0, odd, 10'd15, 1'b0);
		while (cc_send !== 1'b1 && n < 8)
		begin
			@(posedge pclk);
			n++;
		end
		`CHK(cc_send, 1'b1);
		@(posedge pclk);
		`CHK(cc_send, 1'b0);
	endtask

	task automatic close_out;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// whole run needs about 1500 cycles
	initial
	begin
		repeat (40000) @(posedge pclk);
		err_total++;
		close_out();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h000;
		pwdata = 32'h00000000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 11; i++)
			rd_chk(ix_t[i], 8'h00);
		for (i = 0; i < 11; i++)
		begin
			wr(ix_t[i], 8'hFF);
			rd_chk(ix_t[i], msk_t[i]);
			wr(ix_t[i], 8'h00);
		end
		apb(1'b0, 8'h1B, 8'h00);
		`CHK({rerr, rdat}, 33'h100000000);
		wr(IDX_EQ_HIGH, 8'h34);
		wr(IDX_VS_LOW, 8'hFF);
		`CHK({eq_high_total, vs_low_total}, {10'h134, 10'h1FF});
		wr(IDX_F2_OFS, 8'h40);
		`CHK({eq_high_total, vs_low_total}, {10'h234, 10'h2FF});
		src.flags(1'b1, 1'b1);
		wr(IDX_GLK_F1, 8'h40);
		`CHK({pal_phase_flip, field_seq_load}, 2'b10);
		wr(IDX_GLK_F1, 8'h20);
		`CHK({pal_phase_flip, field_seq_load}, 2'b01);
		src.flags(1'b0, 1'b0);
		wr(IDX_GLK_F1, 8'h05);
		wr(IDX_F2_OFS, 8'h1F);
		ln(1'b0, 1'b0, 10'd8, 1'b0);
		`CHK({active_start_line, vbi_blank}, {6'd9, 1'b1});
		ln(1'b0, 1'b0, 10'd9, 1'b0);
		`CHK(vbi_blank, 1'b0);
		ln(1'b0, 1'b1, 10'd40, 1'b0);
		`CHK(active_start_line, 6'd35);
		ln(1'b1, 1'b1, 10'd10, 1'b0);
		`CHK(active_start_line, 6'd6);
		ln(1'b1, 1'b0, 10'd10, 1'b0);
		`CHK(active_start_line, 6'd32);
		ln(1'b0, 1'b1, 10'd283, 1'b1);
		`CHK(half_line_blank, 1'b1);
		ln(1'b1, 1'b1, 10'd23, 1'b1);
		`CHK(half_line_blank, 1'b1);
		wr(IDX_F2_OFS, 8'h3F);
		`CHK(half_line_blank, 1'b0);
		wr(IDX_ODD_PED_HIGH, 8'hC0);
		wr(IDX_ODD_PED_LOW, 8'h82);
		wr(IDX_PED_LEVEL, 8'h16);
		for (i = 0; i < 7; i++)
		begin
			ln(1'b0, po_t[i], pl_t[i], 1'b1);
			`CHK({pedestal_on, comp_pedestal}, {pe_t[i], pe_t[i] ? 7'h16 : 7'h00});
		end
		wr(IDX_PED_LEVEL, 8'hEA);
		ln(1'b0, 1'b1, 10'd273, 1'b1);
		`CHK(comp_pedestal, 7'h6A);
		wr(IDX_CC_FIRST, 8'h41);
		wr(IDX_CC_SECOND, 8'h07);
		wr(IDX_CC_CTL, 8'hE5);
		ln(1'b0, 1'b1, 10'd14, 1'b0);
		`CHK({cc_tx_first, cc_tx_second}, 16'hC107);
		rd_chk(IDX_CC_CTL, 8'hA5);
		cc_pulse(1'b1);
		ln(1'b0, 1'b1, 10'd14, 1'b0);
		`CHK({cc_tx_first, cc_tx_second}, 16'h8080);
		cc_pulse(1'b1);
		wr(IDX_CC_FIRST, 8'h41);
		wr(IDX_CC_SECOND, 8'h87);
		wr(IDX_CC_CTL, 8'hD5);
		ln(1'b0, 1'b1, 10'd14, 1'b0);
		`CHK(cc_tx_first, 8'h80);
		ln(1'b0, 1'b0, 10'd14, 1'b0);
		`CHK({cc_tx_first, cc_tx_second}, 16'h4187);
		cc_pulse(1'b0);
		wr(IDX_CC_CTL, 8'h00);
		for (i = 0; i < 6; i++)
		begin
			wr(IDX_ODD_PED_LOW, rl_t[i][7:0]);
			c0 = f1_cnt;
			src.syncs(lg_t[i]);
			`CHK(f1_cnt - c0, fx_t[i]);
		end
		wr(IDX_ODD_PED_LOW, 8'h00);
		wr(IDX_PDC_START, 8'h0A);
		src.set_line(1'b0, 1'b1, 10'd100, 1'b1);
		src.syncs(99);
		m1 = pdc_at;
		wr(IDX_PDC_START, 8'h14);
		src.syncs(99);
		`CHK(pdc_at - m1, 10);
		src.set_line(1'b0, 1'b1, 10'd100, 1'b0);
		src.syncs(99);
		`CHK(pixel_data_ctl_out, 1'b0);
		// mid-run reset: latched bytes and totals fall back to idle values
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK({cc_tx_first, cc_tx_second, eq_high_total, vs_low_total}, {8'h80, 8'h80, 10'h100, 10'h100});
		rd_chk(IDX_CC_FIRST, 8'h00);
		close_out();
	end
endmodule

// ==== verif/vcp_video_src.sv ====
// upstream video source model: syncs, line state and genlock flags
`timescale 1ns/1ps

module vcp_video_src
(
	// clock
	input  wire logic pclk,
	// sync and line state
	output logic       hsync_input,
	output logic       vsync_input,
	output logic       pal_mode,
	output logic       field_odd,
	output logic [9:0] line_count,
	output logic       active_line,
	// genlock flags
	output logic       pal_phase_flag,
	output logic       color_frame_bit
);
	initial
	begin
		hsync_input = 1'b1;
		vsync_input = 1'b1;
		pal_mode = 1'b0;
		field_odd = 1'b0;
		line_count = 10'h000;
		active_line = 1'b0;
		pal_phase_flag = 1'b0;
		color_frame_bit = 1'b0;
	end

	task automatic set_line(input logic pal, input logic odd, input logic [9:0] ln,
		input logic act);
		@(posedge pclk);
		pal_mode <= pal;
		field_odd <= odd;
		line_count <= ln;
		active_line <= act;
	endtask

	task automatic flags(input logic ph, input logic cf);
		@(posedge pclk);
		pal_phase_flag <= ph;
		color_frame_bit <= cf;
	endtask

	// hsync falls at step 50; a lag past step 99 leaves vsync high
	task automatic syncs(input int lag);
		int i;
		for (i = 0; i < 100; i++)
		begin
			@(posedge pclk);
			if (i == 50)
				hsync_input <= 1'b0;
			if (i == 50 + lag)
				vsync_input <= 1'b0;
		end
		@(posedge pclk);
		hsync_input <= 1'b1;
		vsync_input <= 1'b1;
	endtask
endmodule
